// [hdl/sfc_flash_cmd.sv]
// Purpose: Status and read command handling of a serial flash
// Assumes: Link pins asynchronous to ref_clk, oversampled
// Notes:   Array is a small internal RAM; program/erase are simple timers
//
// How it works
// R1: Write-disable instruction clears write-enable latch
// R2: Latch cleared at reset and after writes
// R3: Read-status returns status repeatedly, even busy
// R4: Host polls busy before new instructions
// R5: Busy bit set during internal cycles
// R6: No writes accepted while latch clear
// R7: Protect bits gate program and sector erase
// R8: Bulk erase only with all protect zero
// R9: Status bits 5 and 6 read zero
// R10: Protect bit with low pin locks status
// R11: Status write is code plus one byte
// R12: Status write keeps bits 6,5,1,0
// R13: Chip select must rise right after byte
// R14: Chip select rise starts timed status write
// R15: Read sends three address bytes, data out
// R16: Fast read adds one dummy byte
// R17: Read address increments and wraps to zero
// R18: Chip select high ends read anywhere
// R19: Reads rejected while internal cycle runs
// R20: Write-enable instruction sets the latch
// R21: All shifting is most significant first
// R22: Write commands need whole byte counts
// R23: Status layout busy, latch, protect, STATUS_PROTECT_BIT
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"

module sfc_flash_cmd
  import sfc_pkg::*;
#(
  parameter int ADDR_W   = 8,                     // Implemented array address bits
  parameter int WS_CYC   = `SFC_STATUS_WRITE_CYC, // Status write time in cycles
  parameter int PROG_CYC = `SFC_PROGRAM_CYC       // Program and erase time in cycles
)
(
  input  wire logic      ref_clk,
  input  wire logic      rstn,
  input  wire sfc_link_s link,
  input  wire logic      writeProtectN,
  output var  logic      serialOut,
  output var  logic      serialOutEn,
  output var  logic [7:0] statusView
);

  // ****************************************************
  // Pin synchronisers and edge detect
  // ****************************************************
  logic [2:0] syncA_r;     // First stage
  logic [2:0] syncB_r;     // Second stage
  logic       sclkOld_r;   // Previous clock level
  logic       csOld_r;     // Previous select level
  logic       wpSync1_r;   // Protect pin stage one
  logic       wpSync2_r;   // Protect pin stage two

  // Two flops on every link pin
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncA_r   <= 3'h7;
      syncB_r   <= 3'h7;
      sclkOld_r <= 1'b0;
      csOld_r   <= 1'b1;
      wpSync1_r <= 1'b1;
      wpSync2_r <= 1'b1;
    end
    else
    begin
      syncA_r   <= {link.csN, link.sclk, link.serialIn};
      syncB_r   <= syncA_r;
      sclkOld_r <= syncB_r[1];
      csOld_r   <= syncB_r[2];
      wpSync1_r <= writeProtectN;
      wpSync2_r <= wpSync1_r;
    end
  end

  wire csN      = syncB_r[2];
  wire sdi      = syncB_r[0];
  wire riseEdge = ~csN & syncB_r[1] & ~sclkOld_r;
  wire fallEdge = ~csN & ~syncB_r[1] & sclkOld_r;
  wire csRise   = csN & ~csOld_r;

  // ****************************************************
  // State
  // ****************************************************
  sfc_phase_e phase_r;          // Interpreter phase
  logic [7:0]  shift_r;         // Input shift register
  logic [2:0]  bitCnt_r;        // Bits within byte
  logic [1:0]  byteCnt_r;       // Address byte count
  logic [7:0]  opcode_r;        // Latched instruction
  logic [23:0] addr_r;          // Read address counter
  logic [7:0]  outByte_r;       // Outgoing byte
  logic        bytes1_r;        // At least one data byte seen
  logic        wel_r;           // Write-enable latch
  logic [2:0]  bp_r;            // Block protect bits
  logic        srp_r;           // Status protect bit
  logic [7:0]  pendStatus_r;    // Status byte to commit
  logic [31:0] busyCnt_r;       // Internal cycle timer
  logic        busy_r;          // Cycle running
  logic        wsCycle_r;       // Running cycle is a status write
  logic        dout_r;          // Serial output flop
  logic [7:0]  mem [0:(1<<ADDR_W)-1]; // Array contents

  wire [7:0] status = {srp_r, 2'b00, bp_r, wel_r, busy_r};      // [R23] [R9]
  wire       hardware_protected_mode    = srp_r & ~wpSync2_r;                       // [R10]
  wire [7:0] rxByte = {shift_r[6:0], sdi};                      // [R21]
  wire       byteDone = riseEdge & (bitCnt_r == 3'h7);
  wire       onBoundary = (bitCnt_r == 3'h0);                   // [R22]
  wire [7:0] memByte = mem[addr_r[ADDR_W-1:0]];
  wire [23:0] addrInc = addr_r + 24'h000001;                    // [R17]
  // Protection of program/sector erase: top fraction selected by bits
  wire [2:0] addrTop = addr_r[23:21];
  wire       protHit = (bp_r != 3'h0) && ({1'b0, addrTop} >= (4'h8 - {1'b0, bp_r})); // [R7]

  // Commit decision at chip select rise
  wire wsGo = csRise && phase_r == SFC_WSDATA && bytes1_r && onBoundary
              && wel_r && !busy_r && !hardware_protected_mode;                      // [R13] [R11] [R6] [R10]
  wire wdGo = csRise && opcode_r == `SFC_OP_WRITE_DISABLE && phase_r == SFC_IGNORE
              && onBoundary && !bytes1_r;                       // [R1] [R22]
  wire weGo = csRise && opcode_r == `SFC_OP_WRITE_ENABLE && phase_r == SFC_IGNORE
              && onBoundary && !bytes1_r && !busy_r;            // [R20]
  wire beGo = csRise && opcode_r == `SFC_OP_BULK_ERASE && phase_r == SFC_IGNORE
              && onBoundary && !bytes1_r && wel_r && !busy_r && bp_r == 3'h0; // [R8] [R6]
  wire ppGo = csRise && opcode_r == `SFC_OP_PAGE_PROGRAM && phase_r == SFC_DATA
              && onBoundary && bytes1_r && wel_r && !busy_r && !protHit;     // [R7] [R6]
  wire seGo = csRise && opcode_r == `SFC_OP_SECTOR_ERASE && phase_r == SFC_DUMMY
              && onBoundary && wel_r && !busy_r && !protHit;                 // [R7] [R6]
  wire cycDone = busy_r && busyCnt_r == 32'h0000_0001;

  // ****************************************************
  // Serial decoder
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r   <= SFC_OPCODE;
      shift_r   <= 8'h00;
      bitCnt_r  <= 3'h0;
      byteCnt_r <= 2'h0;
      opcode_r  <= 8'h00;
      addr_r    <= 24'h000000;
      bytes1_r  <= 1'b0;
      pendStatus_r <= `SFC_ST_RESET;
    end
    else if (csN)
    begin
      // Deselect resets the interpreter and ends any read [R18]
      phase_r   <= SFC_OPCODE;
      bitCnt_r  <= 3'h0;
      byteCnt_r <= 2'h0;
      bytes1_r  <= 1'b0;
    end
    else if (riseEdge)
    begin
      shift_r  <= rxByte;
      bitCnt_r <= bitCnt_r + 3'h1;
      if (byteDone)
      begin
        unique case (phase_r)
          SFC_OPCODE:
          begin
            opcode_r <= rxByte;
            unique case (rxByte)
              `SFC_OP_READ_STATUS:  phase_r <= SFC_STOUT;      // [R3]
              `SFC_OP_WRITE_STATUS: phase_r <= SFC_WSDATA;     // [R11]
              `SFC_OP_READ, `SFC_OP_FAST_READ, `SFC_OP_PAGE_PROGRAM,
              `SFC_OP_SECTOR_ERASE:
                phase_r <= busy_r ? SFC_IGNORE : SFC_ADDR;     // [R19]
              default:              phase_r <= SFC_IGNORE;
            endcase
          end
          SFC_ADDR:
          begin
            addr_r    <= {addr_r[15:0], rxByte};               // [R15]
            byteCnt_r <= byteCnt_r + 2'h1;
            if (byteCnt_r == 2'h2)
            begin
              if (opcode_r == `SFC_OP_FAST_READ)
                phase_r <= SFC_DUMMY;                          // [R16]
              else if (opcode_r == `SFC_OP_SECTOR_ERASE)
                phase_r <= SFC_DUMMY;
              else
                phase_r <= SFC_DATA;
            end
          end
          SFC_DUMMY:
          begin
            // Fast read moves to data; extra byte voids sector erase
            phase_r <= (opcode_r == `SFC_OP_FAST_READ) ? SFC_DATA : SFC_IGNORE;
          end
          SFC_WSDATA:
          begin
            if (bytes1_r)
              phase_r <= SFC_IGNORE;                           // [R13]
            else if (!busy_r)
              pendStatus_r <= rxByte;                          // Running cycle keeps its byte [R19]
            bytes1_r <= 1'b1;
          end
          SFC_DATA:
          begin
            bytes1_r <= 1'b1;
          end
          default:
          begin
            bytes1_r <= 1'b1;
          end
        endcase
      end
    end
    else if (fallEdge && phase_r == SFC_DATA && bitCnt_r == 3'h0 && bytes1_r
             && opcode_r != `SFC_OP_PAGE_PROGRAM)
    begin
      addr_r <= addrInc;                                       // [R17]
    end
    else if (fallEdge && phase_r == SFC_DATA && opcode_r != `SFC_OP_PAGE_PROGRAM)
    begin
      bytes1_r <= 1'b1;
    end
  end

  // ****************************************************
  // Output shifter: load on first fall of byte, shift after
  // ****************************************************
  wire readOut = (phase_r == SFC_DATA) && opcode_r != `SFC_OP_PAGE_PROGRAM;
  wire outLoad = fallEdge && bitCnt_r == 3'h0;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      outByte_r <= 8'h00;
      dout_r    <= 1'b0;
    end
    else if (fallEdge && (readOut || phase_r == SFC_STOUT))
    begin
      if (outLoad)
      begin
        // Next byte: status again, or array byte after increment [R3] [R17]
        outByte_r <= (phase_r == SFC_STOUT) ? {status[6:0], 1'b0}
                   : (bytes1_r ? {mem[addrInc[ADDR_W-1:0]][6:0], 1'b0}
                               : {memByte[6:0], 1'b0});
        dout_r    <= (phase_r == SFC_STOUT) ? status[7]
                   : (bytes1_r ? mem[addrInc[ADDR_W-1:0]][7] : memByte[7]); // [R15] [R21]
      end
      else
      begin
        dout_r    <= outByte_r[7];
        outByte_r <= {outByte_r[6:0], 1'b0};
      end
    end
  end

  assign serialOut   = dout_r;
  assign serialOutEn = ~csN & (readOut | phase_r == SFC_STOUT);

  // ****************************************************
  // Status register and internal cycle timer
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wel_r     <= 1'b0;                                       // [R2]
      bp_r      <= 3'h0;
      srp_r     <= 1'b0;
      busy_r    <= 1'b0;
      wsCycle_r <= 1'b0;
      busyCnt_r <= 32'h0;
    end
    else if (wsGo)
    begin
      busy_r    <= 1'b1;                                       // [R14] [R5]
      wsCycle_r <= 1'b1;
      busyCnt_r <= 32'(WS_CYC);
    end
    else if (ppGo || seGo || beGo)
    begin
      busy_r    <= 1'b1;                                       // [R5]
      wsCycle_r <= 1'b0;
      busyCnt_r <= 32'(PROG_CYC);
    end
    else if (cycDone)
    begin
      busy_r    <= 1'b0;
      wel_r     <= 1'b0;                                       // [R2] [R14]
      busyCnt_r <= 32'h0;
      if (wsCycle_r)
      begin
        // Only protect bits change [R12] [R7]
        bp_r  <= pendStatus_r[`SFC_ST_BP_HI:`SFC_ST_BP_LO];
        srp_r <= pendStatus_r[`SFC_ST_SRP];
      end
    end
    else
    begin
      if (busy_r)
        busyCnt_r <= busyCnt_r - 32'h1;
      if (wdGo)
        wel_r <= 1'b0;                                         // [R1]
      else if (weGo)
        wel_r <= 1'b1;                                         // [R20]
    end
  end

  assign statusView = status;

  // ****************************************************
  // Array write on page program data (simple model)
  // ****************************************************
  always_ff @(posedge ref_clk)
  begin
    if (byteDone && phase_r == SFC_DATA && opcode_r == `SFC_OP_PAGE_PROGRAM
        && wel_r && !busy_r && !protHit)
      mem[addr_r[ADDR_W-1:0]] <= rxByte;
  end

  // ****************************************************
  // Checks
  // ****************************************************
  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn) // [R9]
    statusView[6:5] == 2'b00) else $error("Reserved status bits not zero");

  AST_WS_SETS_BUSY: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
    wsGo |=> busy_r && wsCycle_r) else $error("Status write did not start cycle");

  AST_DONE_CLEARS_WEL: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
    cycDone |=> !wel_r && !busy_r) else $error("Cycle end left latch or busy");

  AST_WD_CLEARS: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
    wdGo |=> !wel_r) else $error("Write disable failed");

  AST_WE_SETS: assert property (@(posedge ref_clk) disable iff (!rstn) // [R20]
    weGo && !cycDone |=> wel_r) else $error("Write enable failed");

  AST_NO_WEL_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
    !wel_r |-> !wsGo && !ppGo && !seGo && !beGo) else $error("Write accepted without latch");

  AST_HPM_LOCK: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
    hardware_protected_mode && !busy_r |=> $stable(bp_r) && $stable(srp_r)) else $error("Protect bits changed in HARDWARE_PROTECTED_MODE");

  AST_BE_PROTECT: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    beGo |-> bp_r == 3'h0) else $error("Bulk erase with protection");

  AST_READ_BUSY_REJECT: assert property (@(posedge ref_clk) disable iff (!rstn) // [R19]
    busy_r && byteDone && phase_r == SFC_OPCODE && rxByte == `SFC_OP_READ
    |=> phase_r == SFC_IGNORE) else $error("Read accepted while busy");

  AST_DESELECT_ENDS: assert property (@(posedge ref_clk) disable iff (!rstn) // [R18]
    csN |=> phase_r == SFC_OPCODE && !serialOutEn) else $error("Deselect did not end command");

  AST_ADDR_WRAP: assert property (@(posedge ref_clk) disable iff (!rstn) // [R17]
    fallEdge && readOut && onBoundary && bytes1_r && addr_r == 24'hFFFFFF
    |=> addr_r == `SFC_ADDR_WRAP) else $error("Read address did not wrap");

endmodule

`default_nettype wire

// [include/sfc_defines.svh]
// Purpose: Constants for the serial flash command interpreter
// Assumes: Single 125 MHz core clock
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// ****************************************************
// Instruction codes
// ****************************************************
`define SFC_OP_WRITE_STATUS   8'h01
`define SFC_OP_READ           8'h03
`define SFC_OP_WRITE_DISABLE  8'h04
`define SFC_OP_READ_STATUS    8'h05
`define SFC_OP_WRITE_ENABLE   8'h06
`define SFC_OP_FAST_READ      8'h0B
`define SFC_OP_PAGE_PROGRAM   8'h02
`define SFC_OP_SECTOR_ERASE   8'hD8
`define SFC_OP_BULK_ERASE     8'hC7

// ****************************************************
// Status field positions
// ****************************************************
`define SFC_ST_BUSY           0
`define SFC_ST_WEL            1
`define SFC_ST_BP_LO          2
`define SFC_ST_BP_HI          4
`define SFC_ST_SRP            7
`define SFC_ST_WMASK          8'h9C
`define SFC_ST_RESET          8'h00

// ****************************************************
// Timing
// ****************************************************
`define SFC_CLK_PERIOD_NS     8
`define SFC_STATUS_WRITE_NS   10000
`define SFC_STATUS_WRITE_CYC  ((`SFC_STATUS_WRITE_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
`define SFC_PROGRAM_CYC       4000
`define SFC_ADDR_WRAP         24'h000000

`endif

// [include/sfc_pkg.sv]
// Purpose: Types for the serial flash command interpreter
// Assumes: Included defines header
// Notes:   States and pin carriers
package sfc_pkg;

  // Interpreter phases
  typedef enum logic [2:0] {
    SFC_OPCODE = 3'b000,
    SFC_ADDR   = 3'b001,
    SFC_DUMMY  = 3'b010,
    SFC_DATA   = 3'b011,
    SFC_STOUT  = 3'b100,
    SFC_WSDATA = 3'b101,
    SFC_IGNORE = 3'b110
  } sfc_phase_e;

  // Serial pin group from the host
  typedef struct packed {
    logic csN;
    logic sclk;
    logic serialIn;
  } sfc_link_s;

endpackage

// [sim/sfc_host_model.sv]
// Purpose: Host controller model that frames instructions on the serial link
// Assumes: Link clock parked low between frames, 160 ns period
// Notes:   Reports each received byte with a one-cycle rxValid pulse
`timescale 1ns/1ps
`default_nettype none

module sfc_host_model
  import sfc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       serialOut,
  input  wire logic       serialOutEn,
  output var  sfc_link_s  link,
  output var  logic [7:0] rxByte,
  output var  logic       rxValid,
  output var  logic       rxEnAll,
  output var  logic       hdrEnAny,
  output var  logic [7:0] tailEnCnt
);
  logic seenOut;  // Data out seen at the last link clock rise
  logic seenEn;   // Output enable seen at the same rise

  // ****************************************************
  // Idle state: deselected, clock parked low
  // ****************************************************
  initial
  begin
    link = 3'b100;
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxEnAll = 1'b0;
    hdrEnAny = 1'b0;
    tailEnCnt = 8'h00;
  end

  // Half a link clock, launched just after a core clock edge
  task automatic half();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  // One link clock: data in set while low, data out taken at the rise
  task automatic clk1(input logic din);
    link.serialIn = din;
    half();
    link.sclk = 1'b1;
    // Undriven line shows the inverse of the last bit
    seenOut = serialOutEn ? serialOut : ~serialOut;
    seenEn = serialOutEn;
    half();
    link.sclk = 1'b0;
  endtask

  // Whole frame: header bytes, received bytes, then loose clocks
  task automatic frame(input logic [39:0] tx, input int nTx, input int nRx, input int nExtra);
    int i;
    link.csN = 1'b0;
    hdrEnAny = 1'b0;
    rxEnAll = 1'b1;
    tailEnCnt = 8'h00;
    half();
    for (i = 0; i < 8 * nTx; i++)
    begin
      clk1(tx[39 - i]);
      hdrEnAny = hdrEnAny | seenEn;
    end
    for (i = 0; i < 8 * nRx; i++)
    begin
      // Data in is not used here, so it keeps toggling
      clk1(~link.serialIn);
      rxByte = {rxByte[6:0], seenOut};
      rxEnAll = rxEnAll & seenEn;
      if (i % 8 == 7)
      begin
        rxValid = 1'b1;
        @(posedge ref_clk);
        #1;
        rxValid = 1'b0;
      end
    end
    for (i = 0; i < nExtra; i++)
    begin
      clk1(~link.serialIn);
      tailEnCnt = tailEnCnt + {7'h00, seenEn};
    end
    half();
    link.csN = 1'b1;
    half();
  endtask
endmodule

`default_nettype wire

// [sim/test_sfc_flash_cmd.sv]
// Purpose: Self-checking bench for the flash command interpreter
// Assumes: Host model drives the link; expected status bytes are queued
// Notes:   Status write time shortened to 1000 core cycles
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"

module test_sfc_flash_cmd
  import sfc_pkg::*;
();
  logic       ref_clk;        // Core clock
  logic       rstn;           // Active low reset
  logic       writeProtectN;  // Write protect pin
  sfc_link_s  link;           // Link pins from the host
  logic       serialOut;      // Data out
  logic       serialOutEn;    // Data out enable
  logic [7:0] statusView;     // Live status
  logic [7:0] rxByte;         // Byte taken by the host
  logic       rxValid;        // Byte ready pulse
  logic       rxEnAll;        // Enable held over received bits
  logic       hdrEnAny;       // Enable seen during the header
  logic [7:0] tailEnCnt;      // Loose clocks with enable high
  logic [7:0] expQ[$];        // Expected received bytes
  logic [7:0] rnd;            // Random status data
  logic [7:0] expSt;          // Expected status after the write
  logic [7:0] dTop;           // Byte programmed at the top address
  logic [7:0] dBase;          // Byte programmed at address zero
  int         errors = 0;
  int         checks = 0;

  sfc_flash_cmd #(.ADDR_W(8), .WS_CYC(1000), .PROG_CYC(20)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .link(link), .writeProtectN(writeProtectN),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .statusView(statusView));

  sfc_host_model host (
    .ref_clk(ref_clk), .serialOut(serialOut), .serialOutEn(serialOutEn), .link(link),
    .rxByte(rxByte), .rxValid(rxValid), .rxEnAll(rxEnAll), .hdrEnAny(hdrEnAny),
    .tailEnCnt(tailEnCnt));

  // ****************************************************
  // Clock, watchdog and shared tasks
  // ****************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cuts a hang short; the run needs about 120 us
  initial
  begin
    #400000;
    errors = errors + 1;
    conclude();
  end

  // Byte compare, also used for flags widened to a byte
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      errors = errors + 1;
    end
  endtask

  // Single byte instruction
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 32'h0}, 1, 0, 0);
  endtask

  // Status read of n bytes, each noted beforehand
  task automatic rdst(input logic [7:0] exp, input int n);
    repeat (n) expQ.push_back(exp);
    host.frame({`SFC_OP_READ_STATUS, 32'h0}, 1, n, 0);
  endtask

  // Polls busy under a bound
  task automatic idle();
    int k;
    for (k = 0; k < 3000 && statusView[0] !== 1'b0; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
    cmp8({7'h00, statusView[0]}, 8'h00);
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Takes the oldest note whenever the host reports a byte
  always @(posedge ref_clk)
  begin
    if (rxValid === 1'b1)
    begin
      cmp8(rxByte, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
      cmp8({7'h00, rxEnAll}, 8'h01);
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    void'($urandom(32'hBA747E7D));
    rstn = 1'b0;
    writeProtectN = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    cmp8(statusView, `SFC_ST_RESET);
    rdst(8'h00, 1);
    cmd(`SFC_OP_WRITE_ENABLE);
    rdst(8'h02, 2);
    cmd(`SFC_OP_WRITE_DISABLE);
    rdst(8'h00, 1);
    // Write disable closed one clock past the byte is refused
    cmd(`SFC_OP_WRITE_ENABLE);
    host.frame({`SFC_OP_WRITE_DISABLE, 32'h0}, 1, 0, 1);
    rdst(8'h02, 1);
    // Extra byte after the status data voids the write
    host.frame({`SFC_OP_WRITE_STATUS, 16'h9C00, 16'h0}, 3, 0, 0);
    rdst(8'h02, 1);
    cmd(`SFC_OP_WRITE_DISABLE);
    host.frame({`SFC_OP_WRITE_STATUS, 8'h9C, 24'h0}, 2, 0, 0);
    rdst(8'h00, 1);
    // Random status write with the protect bit set
    rnd = 8'($urandom);
    rnd[7] = 1'b1;
    rnd[2] = 1'b1;
    expSt = rnd & `SFC_ST_WMASK;
    cmd(`SFC_OP_WRITE_ENABLE);
    host.frame({`SFC_OP_WRITE_STATUS, rnd, 24'h0}, 2, 0, 0);
    rdst(8'h03, 2);
    host.frame({`SFC_OP_READ, 24'($urandom), 8'h00}, 4, 0, 8);
    cmp8(tailEnCnt, 8'h00);
    idle();
    rdst(expSt, 1);
    cmp8(statusView & 8'h60, 8'h00);
    // Bulk erase is refused while a protect bit is set
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_BULK_ERASE);
    rdst(expSt | 8'h02, 1);
    // Locked status refuses the write and keeps the latch
    writeProtectN = 1'b0;
    cmd(`SFC_OP_WRITE_ENABLE);
    host.frame({`SFC_OP_WRITE_STATUS, 8'h00, 24'h0}, 2, 0, 0);
    rdst(expSt | 8'h02, 1);
    writeProtectN = 1'b1;
    host.frame({`SFC_OP_WRITE_STATUS, 8'h00, 24'h0}, 2, 0, 0);
    idle();
    rdst(8'h00, 1);
    // Program the top and bottom bytes, then read across the wrap
    dTop = 8'($urandom);
    dBase = 8'($urandom);
    cmd(`SFC_OP_WRITE_ENABLE);
    host.frame({`SFC_OP_PAGE_PROGRAM, 24'hFFFFFF, dTop}, 5, 0, 0);
    idle();
    cmd(`SFC_OP_WRITE_ENABLE);
    host.frame({`SFC_OP_PAGE_PROGRAM, 24'h000000, dBase}, 5, 0, 0);
    idle();
    expQ.push_back(dTop);
    expQ.push_back(dBase);
    host.frame({`SFC_OP_READ, 24'hFFFFFF, 8'h00}, 4, 2, 0);
    // Read across the top of the address space, cut mid byte
    host.frame({`SFC_OP_READ, 24'hFFFFFE, 8'h00}, 4, 0, 20);
    cmp8({7'h00, hdrEnAny}, 8'h00);
    cmp8(tailEnCnt, 8'h14);
    cmp8({7'h00, serialOutEn}, 8'h00);
    host.frame({`SFC_OP_FAST_READ, 24'($urandom), 8'hA5}, 5, 0, 12);
    cmp8({7'h00, hdrEnAny}, 8'h00);
    cmp8(tailEnCnt, 8'h0C);
    conclude();
  end
endmodule

`default_nettype wire
